/* dv/test_tsl_top.sv */
// Self-checking bench for tsl_top over its serial pins and converter link
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD %0t got %h expected %h", $time, g, e); end end
module test_tsl_top;
   localparam int         BASE  = 200;
   localparam logic [2:0] STRAP = 3'h5;
   int          error_cnt   = 0;
   int          check_count = 0;
   logic        mclk      = 1'b0;
   logic        rst       = 1'b1;
   logic        adc_clk   = 1'b0;
   logic        adc_rst   = 1'b1;
   logic [11:0] adc_word  = 12'h000;
   logic        adc_valid = 1'b0;
   logic        scl;
   logic        m_sda;
   logic        sda_out;
   logic        sda_oe;
   logic        alarm;
   logic        conv;
   logic        ack;
   wire logic   sda = (sda_oe ? sda_out : 1'b1) & m_sda;
   tsl_top #(.CONV_BASE_CYCLES(BASE)) i_tsl_top (.mclk_i(mclk), .rst_i(rst),
      .adc_clk_i(adc_clk), .adc_rst_i(adc_rst), .adc_sample_i(adc_word),
      .adc_valid_i(adc_valid), .scl_i(scl), .sda_i(sda), .sda_o(sda_out),
      .sda_oe_o(sda_oe), .address_strap_pins_i(STRAP), .alarm_output_o(alarm),
      .converting_o(conv));
   tsl_master i_tsl_master (.clk_i(mclk), .scl_o(scl), .sda_o(m_sda), .sda_i(sda));
   // Clocks; link clock offset so its edges never meet the main clock's
   initial forever #2.5 mclk = ~mclk;
   initial begin
      #0.7;
      forever #3 adc_clk = ~adc_clk;
   end
   // Converter words every 21 link cycles, well apart for the crossing
   initial forever begin
      repeat (20) @(negedge adc_clk);
      adc_valid = 1'b1;
      @(negedge adc_clk);
      adc_valid = 1'b0;
   end
   task automatic print_verdict();
      if (error_cnt == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic open_bus(input logic rd_n);
      i_tsl_master.start();
      i_tsl_master.put({tsl_pkg::ADDR_FIXED, STRAP, rd_n}, ack);
      `CHK(ack, 1'b1)
   endtask
   // Pointer then n data bytes from the top of d
   task automatic wr(input logic [7:0] p, input int n, input logic [23:0] d);
      open_bus(1'b0);
      i_tsl_master.put(p, ack);
      `CHK(ack, 1'b1)
      for (int i = 0; i < n; i++) begin
         i_tsl_master.put(d[23 - 8 * i -: 8], ack);
         `CHK(ack, 1'b1)
      end
      i_tsl_master.stop();
   endtask
   task automatic rd(input logic [23:0] e, input int n);
      logic [7:0] b;
      open_bus(1'b1);
      for (int i = 0; i < n; i++) begin
         i_tsl_master.get(i < n - 1, b);
         `CHK(b, e[23 - 8 * i -: 8])
      end
      i_tsl_master.stop();
   endtask
   // Bounded wait; a miss ends the run
   task automatic wait_conv(input logic v, input int lim);
      for (int k = 0; k < lim && conv !== v; k++) @(negedge mclk);
      `CHK(conv, v)
      if (conv !== v) print_verdict();
   endtask
   initial begin
      repeat (6) @(negedge mclk);
      rst = 1'b0;
      adc_rst = 1'b0;
      repeat (4) @(negedge mclk);
      wr(8'h01, 0, 24'h0);
      rd(24'h000000, 2);
      wr(8'h02, 0, 24'h0);
      rd(24'h4b0000, 2);
      wr(8'h01, 1, 24'hf40000);
      rd(24'h740000, 2);
      `CHK(conv, 1'b1)
      // Limit masked at 12 bits, pointer kept, master ACK restarts
      wr(8'h02, 2, 24'h12ab00);
      rd(24'h12a012, 3);
      wr(8'h03, 1, 24'h770000);
      rd(24'h500000, 2);
      wr(8'h03, 3, 24'h112233);
      rd(24'h112000, 2);
      // Other strap address and unmapped pointer refused
      i_tsl_master.start();
      i_tsl_master.put({tsl_pkg::ADDR_FIXED, 3'h2, 1'b0}, ack);
      `CHK(ack, 1'b0)
      open_bus(1'b0);
      i_tsl_master.put(8'h04, ack);
      `CHK(ack, 1'b0)
      i_tsl_master.stop();
      // Queue of four at 9 bits; waits allow for conversion phase
      wr(8'h01, 2, 24'h14ff00);
      `CHK(alarm, 1'b0)
      repeat (1700) @(negedge mclk);
      adc_word = 12'h7ff;
      repeat (500) @(negedge mclk);
      `CHK(alarm, 1'b0)
      repeat (800) @(negedge mclk);
      `CHK(alarm, 1'b1)
      wr(8'h01, 1, 24'h100000);
      `CHK(alarm, 1'b0)
      adc_word = 12'h000;
      repeat (1300) @(negedge mclk);
      `CHK(alarm, 1'b1)
      // Power-down, one-shot, then resume
      wr(8'h01, 1, 24'h010000);
      wait_conv(1'b0, 400);
      repeat (400) @(negedge mclk);
      `CHK(conv, 1'b0)
      wr(8'h01, 1, 24'h810000);
      `CHK(conv, 1'b1)
      repeat (120) @(negedge mclk);
      `CHK(conv, 1'b1)
      wait_conv(1'b0, 40);
      rd(24'h010000, 2);
      wr(8'h01, 1, 24'h000000);
      wait_conv(1'b1, 100);
      // Interrupt style: trip sets the flag, a read address clears it
      wr(8'h01, 1, 24'h020000);
      `CHK(alarm, 1'b1)
      adc_word = 12'h7ff;
      repeat (300) @(negedge mclk);
      `CHK(alarm, 1'b0)
      wr(8'h00, 0, 24'h0);
      rd(24'h7f8000, 2);
      `CHK(alarm, 1'b1)
      print_verdict();
   end
endmodule // test_tsl_top
`default_nettype wire

/* dv/tsl_master.sv */
// Bus master model driving the serial clock and data pins
`timescale 1ns/100ps
`default_nettype none
module tsl_master (
   // Clock
   input  wire logic clk_i,
   // Bus pins; data released means high via pull-up
   output var logic  scl_o,
   output var logic  sda_o,
   input  wire logic sda_i
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Half bit of 12 clocks; the slave asks for 10
   task automatic gap();
      repeat (12) @(negedge clk_i);
   endtask
   // Clock falls, then data waits 2 clocks so no false start or stop
   task automatic fall();
      scl_o = 1'b0;
      repeat (2) @(negedge clk_i);
   endtask
   task automatic clk_bit(input logic b, output logic r);
      sda_o = b;
      gap();
      scl_o = 1'b1;
      gap();
      r = sda_i;
      fall();
   endtask
   task automatic start();
      sda_o = 1'b1;
      gap();
      scl_o = 1'b1;
      gap();
      sda_o = 1'b0;
      gap();
      fall();
   endtask
   task automatic stop();
      sda_o = 1'b0;
      gap();
      scl_o = 1'b1;
      gap();
      sda_o = 1'b1;
      gap();
   endtask
   // Byte out MSB first; ninth clock samples the answer
   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
      clk_bit(1'b1, r);
      ack = !r;
   endtask
   // Byte in; more gives ACK to go on, else NACK
   task automatic get(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
      clk_bit(!more, r);
   endtask
endmodule // tsl_master
`default_nettype wire

/* dv/tsl_properties.sv */
// Checker for bus pin timing and conversion stretches of tsl_top
`timescale 1ns/100ps
`default_nettype none
module tsl_properties #(
   parameter int CONV_BASE_CYCLES = 50
) (
   // Watched ports
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic alarm_output_o,
   input wire logic converting_o
);
   int run_cnt;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // Length of the current converting stretch
   always_ff @(posedge mclk_i) run_cnt <= (rst_i || !converting_o) ? 0 : run_cnt + 1;
   property p_rst_levels; disable iff (1'b0)
      rst_i |=> !sda_oe_o && alarm_output_o && converting_o; endproperty
   a_rst_levels: assert property (p_rst_levels) else $error("reset levels wrong");
   property p_pull_only; sda_oe_o |-> !sda_o; endproperty
   a_pull_only: assert property (p_pull_only) else $error("data pin driven high");
   property p_hold_high; scl_i && $past(scl_i) |-> $stable(sda_oe_o); endproperty
   a_hold_high: assert property (p_hold_high) else $error("data moved, clock high");
   property p_ack_late; $rose(sda_oe_o) |-> !$past(scl_i, 2); endproperty
   a_ack_late: assert property (p_ack_late) else $error("drive began too early");
   property p_ack_holds; $rose(sda_oe_o) |-> sda_oe_o [*8]; endproperty
   a_ack_holds: assert property (p_ack_holds) else $error("drive too short");
   property p_stop_free; scl_i && $past(scl_i) && $rose(sda_i) |=> !sda_oe_o [*8]; endproperty
   a_stop_free: assert property (p_stop_free) else $error("drive after stop");
   property p_conv_len; $fell(converting_o) |-> run_cnt >= CONV_BASE_CYCLES - 2; endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion too short");
   property p_run_min; $rose(converting_o) |=> converting_o [*8]; endproperty
   a_run_min: assert property (p_run_min) else $error("one-shot run too short");
   // Main scenarios reached
   c_ack: cover property ($rose(sda_oe_o));
   c_down: cover property ($fell(converting_o));
   c_alarm: cover property ($changed(alarm_output_o));
endmodule // tsl_properties
bind tsl_top tsl_properties #(.CONV_BASE_CYCLES(CONV_BASE_CYCLES)) i_tsl_properties (
   .mclk_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .alarm_output_o, .converting_o);
`default_nettype wire

/* logic/tsl_pkg.sv */
// Package: constants for the temperature sensor control and limit block
package tsl_pkg;
   // Bus address: fixed upper bits, lower bits from straps
   localparam logic [3:0]  ADDR_FIXED      = 4'h9;
   // Pointer codes
   localparam logic [1:0]  PTR_TEMP        = 2'h0;
   localparam logic [1:0]  PTR_CONTROL     = 2'h1;
   localparam logic [1:0]  PTR_LOW_LIMIT   = 2'h2;
   localparam logic [1:0]  PTR_HIGH_LIMIT  = 2'h3;
   localparam logic [7:0]  PTR_MAX         = 8'h03;
   // Control byte field positions (upper byte of sensor_control)
   localparam int          ONE_SHOT_POS    = 7;
   localparam int          RES_POS         = 5;
   localparam int          QUEUE_POS       = 3;
   localparam int          LEVEL_POS       = 2;
   localparam int          STYLE_POS       = 1;
   localparam int          POWER_DOWN_POS  = 0;
   // Reset values
   localparam logic [1:0]  RES_RESET       = 2'h0;
   localparam logic [1:0]  QUEUE_RESET     = 2'h0;
   localparam logic [15:0] LOW_LIMIT_RESET = 16'h4b00;
   localparam logic [15:0] HIGH_LIMIT_RESET = 16'h5000;
   localparam logic [15:0] TEMP_RESET      = 16'h0000;
   // Consecutive faults required per queue_depth code
   localparam logic [2:0]  QUEUE_NEED_0    = 3'h1;
   localparam logic [2:0]  QUEUE_NEED_1    = 3'h2;
   localparam logic [2:0]  QUEUE_NEED_2    = 3'h4;
   localparam logic [2:0]  QUEUE_NEED_3    = 3'h6;
   // Conversion times in ms; each resolution step doubles the time
   localparam int          CONV_TIME_9B_MS  = 25;
   localparam int          CONV_TIME_10B_MS = 50;
   localparam int          CONV_TIME_11B_MS = 100;
   localparam int          CONV_TIME_12B_MS = 200;
   localparam int          CLK_FREQ_KHZ     = 200000;
   localparam int          CONV_9B_CYCLES   = CONV_TIME_9B_MS * CLK_FREQ_KHZ;
   // Serial engine states
   typedef enum logic [4:0] {
      SER_IDLE = 5'b00001,
      SER_RX   = 5'b00010,
      SER_RACK = 5'b00100,
      SER_TX   = 5'b01000,
      SER_TACK = 5'b10000
   } tsl_ser_type;
   // Conversion states
   typedef enum logic [1:0] {
      CONV_RUN  = 2'b01,
      CONV_SHUT = 2'b10
   } tsl_conv_type;
endpackage

/* logic/tsl_top.sv */
// Temperature sensor control, limits, conversion sequencing and serial slave
`timescale 1ns/100ps
`default_nettype none
module tsl_top #(
   parameter int CONV_BASE_CYCLES = tsl_pkg::CONV_9B_CYCLES
) (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   // Converter domain
   input  wire logic        adc_clk_i,
   input  wire logic        adc_rst_i,
   input  wire logic [11:0] adc_sample_i,
   input  wire logic        adc_valid_i,
   // Serial bus pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   // Address straps
   input  wire logic [2:0]  address_strap_pins_i,
   // Alarm and status
   output logic             alarm_output_o,
   output logic             converting_o
);

   // Resolution mask: keep sign plus resolution-dependent data bits
   function automatic logic [15:0] res_mask(input logic [1:0] res);
      res_mask = 16'hff80 | (16'hff80 >> res);
   endfunction

   // Pin synchronisers and edge history
   logic       scl_m, scl_s, scl_d;
   logic       sda_m, sda_s, sda_d;
   logic [2:0] strap_m, strap_s;

   always_ff @(posedge mclk_i) begin
      scl_m   <= scl_i;
      scl_s   <= scl_m;
      scl_d   <= scl_s;
      sda_m   <= sda_i;
      sda_s   <= sda_m;
      sda_d   <= sda_s;
      strap_m <= address_strap_pins_i;
      strap_s <= strap_m;
   end

   // Bus conditions from the second synchroniser stage onward
   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

   // Converter-domain capture: hold word, flip a toggle per sample
   logic [11:0] adc_hold;
   logic        adc_tog;

   always_ff @(posedge adc_clk_i) begin
      if (adc_rst_i) begin
         adc_hold <= 12'h000;
         adc_tog  <= 1'b0;
      end else if (adc_valid_i) begin
         adc_hold <= adc_sample_i;
         adc_tog  <= ~adc_tog;
      end
   end

   // Toggle crossing; word is stable long before the synced edge arrives
   logic        tog_m, tog_s, tog_d;
   logic [11:0] adc_word;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tog_m    <= 1'b0;
         tog_s    <= 1'b0;
         tog_d    <= 1'b0;
         adc_word <= 12'h000;
      end else begin
         tog_m <= adc_tog;
         tog_s <= tog_m;
         tog_d <= tog_s;
         if (tog_s ^ tog_d) begin
            adc_word <= adc_hold;
         end
      end
   end

   // Control fields and limit registers
   logic         one_shot_request;
   logic [1:0]   resolution_select;
   logic [1:0]   queue_depth;
   logic         alert_active_level;
   logic         alarm_style_select;
   logic         power_down_bit;
   logic [15:0]  low_alarm_limit;
   logic [15:0]  high_alarm_limit;
   logic [15:0]  temp_reg;

   // Serial engine state
   tsl_pkg::tsl_ser_type ser_state;
   logic [7:0]   shreg;
   logic [3:0]   bitcnt;
   logic         addr_phase;
   logic         rw_read;
   logic [1:0]   byte_idx;
   logic [1:0]   pointer;
   logic [7:0]   lim_upper;
   logic         byte_lo;
   logic         master_ack;
   logic         cfg_we;
   logic         lim_we;
   logic [15:0]  wr_word;
   logic         rd_pulse;

   // Read data selection by persistent pointer
   wire [7:0]  cfg_byte = {1'b0, resolution_select, queue_depth,
                           alert_active_level, alarm_style_select,
                           power_down_bit};
   wire [15:0] rd_word  = (pointer == tsl_pkg::PTR_TEMP)    ? temp_reg :
                          (pointer == tsl_pkg::PTR_CONTROL) ? {cfg_byte, 8'h00} :
                          (pointer == tsl_pkg::PTR_LOW_LIMIT) ?
                          (low_alarm_limit & res_mask(resolution_select)) :
                          (high_alarm_limit & res_mask(resolution_select));
   wire [7:0]  next_tx  = byte_lo ? rd_word[7:0] : rd_word[15:8];
   wire        byte_end = (bitcnt == 4'h8);
   wire        addr_hit = (shreg[7:1] == {tsl_pkg::ADDR_FIXED, strap_s});
   // Data to the temperature register is refused; bad pointers refused
   wire        ptr_ok   = (shreg <= tsl_pkg::PTR_MAX);
   wire        data_ack = (byte_idx == 2'h0) ? ptr_ok : (pointer != tsl_pkg::PTR_TEMP);
   wire        is_limit = pointer[1];

   // Serial slave: start/stop restart the frame and drop partial bytes
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ser_state  <= tsl_pkg::SER_IDLE;
         shreg      <= 8'h00;
         bitcnt     <= 4'h0;
         addr_phase <= 1'b0;
         rw_read    <= 1'b0;
         byte_idx   <= 2'h0;
         pointer    <= tsl_pkg::PTR_TEMP;
         lim_upper  <= 8'h00;
         byte_lo    <= 1'b0;
         master_ack <= 1'b0;
         sda_oe_o   <= 1'b0;
         cfg_we     <= 1'b0;
         lim_we     <= 1'b0;
         wr_word    <= 16'h0000;
         rd_pulse   <= 1'b0;
      end else begin
         cfg_we   <= 1'b0;
         lim_we   <= 1'b0;
         rd_pulse <= 1'b0;
         if (start_c) begin
            ser_state  <= tsl_pkg::SER_RX;
            bitcnt     <= 4'h0;
            addr_phase <= 1'b1;
            sda_oe_o   <= 1'b0;
         end else if (stop_c) begin
            ser_state <= tsl_pkg::SER_IDLE;
            sda_oe_o  <= 1'b0;
         end else begin
            case (ser_state)
               tsl_pkg::SER_RX: begin
                  if (scl_rise && !byte_end) begin
                     shreg  <= {shreg[6:0], sda_s};
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall && byte_end) begin
                     if (addr_phase) begin
                        if (addr_hit) begin
                           rw_read    <= shreg[0];
                           rd_pulse   <= shreg[0];
                           addr_phase <= 1'b0;
                           byte_idx   <= 2'h0;
                           sda_oe_o   <= 1'b1;
                           ser_state  <= tsl_pkg::SER_RACK;
                        end else begin
                           ser_state <= tsl_pkg::SER_IDLE;
                        end
                     end else begin
                        sda_oe_o  <= data_ack;
                        ser_state <= tsl_pkg::SER_RACK;
                        if (byte_idx != 2'h3) begin
                           byte_idx <= byte_idx + 2'h1;
                        end
                        if (byte_idx == 2'h0 && ptr_ok) begin
                           pointer <= shreg[1:0];
                        end else if (byte_idx == 2'h1 && pointer == tsl_pkg::PTR_CONTROL) begin
                           cfg_we  <= 1'b1;
                           wr_word <= {shreg, 8'h00};
                        end else if (byte_idx == 2'h1 && is_limit) begin
                           lim_upper <= shreg;
                        end else if (byte_idx == 2'h2 && is_limit) begin
                           lim_we  <= 1'b1;
                           wr_word <= {lim_upper, shreg};
                        end
                     end
                  end
               end
               tsl_pkg::SER_RACK: begin
                  if (scl_fall) begin
                     bitcnt <= 4'h0;
                     if (rw_read) begin
                        byte_lo   <= 1'b1;
                        shreg     <= rd_word[15:8];
                        sda_oe_o  <= ~rd_word[15];
                        ser_state <= tsl_pkg::SER_TX;
                     end else begin
                        sda_oe_o  <= 1'b0;
                        ser_state <= tsl_pkg::SER_RX;
                     end
                  end
               end
               tsl_pkg::SER_TX: begin
                  if (scl_fall) begin
                     if (bitcnt == 4'h7) begin
                        sda_oe_o  <= 1'b0;
                        ser_state <= tsl_pkg::SER_TACK;
                     end else begin
                        shreg    <= {shreg[6:0], 1'b0};
                        bitcnt   <= bitcnt + 4'h1;
                        sda_oe_o <= ~shreg[6];
                     end
                  end
               end
               tsl_pkg::SER_TACK: begin
                  if (scl_rise) begin
                     master_ack <= ~sda_s;
                  end else if (scl_fall) begin
                     if (master_ack) begin
                        byte_lo   <= ~byte_lo;
                        shreg     <= next_tx;
                        sda_oe_o  <= ~next_tx[7];
                        bitcnt    <= 4'h0;
                        ser_state <= tsl_pkg::SER_TX;
                     end else begin
                        ser_state <= tsl_pkg::SER_IDLE;
                     end
                  end
               end
               default: begin
                  ser_state <= tsl_pkg::SER_IDLE;
               end
            endcase
         end
      end
   end

   // Open-drain data pin only ever pulls low
   always_ff @(posedge mclk_i) begin
      sda_o <= 1'b0;
   end

   // Conversion sequencing
   tsl_pkg::tsl_conv_type conv_state;
   logic [31:0]  conv_timer;
   wire  [31:0]  conv_len  = 32'(CONV_BASE_CYCLES) << resolution_select;
   wire          conv_done = (conv_state == tsl_pkg::CONV_RUN) &&
                             (conv_timer >= conv_len - 32'h1);    // Shorter resolution mid-run
   wire  [15:0]  new_temp  = {adc_word, 4'h0} & res_mask(resolution_select);
   wire          pd_wr     = wr_word[8 + tsl_pkg::POWER_DOWN_POS];

   // Control fields; one-shot accepted only while powered down
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         one_shot_request   <= 1'b0;
         resolution_select  <= tsl_pkg::RES_RESET;
         queue_depth        <= tsl_pkg::QUEUE_RESET;
         alert_active_level <= 1'b0;
         alarm_style_select <= 1'b0;
         power_down_bit     <= 1'b0;
      end else begin
         if (cfg_we) begin
            resolution_select  <= wr_word[9 + tsl_pkg::RES_POS -: 2];
            queue_depth        <= wr_word[9 + tsl_pkg::QUEUE_POS -: 2];
            alert_active_level <= wr_word[8 + tsl_pkg::LEVEL_POS];
            alarm_style_select <= wr_word[8 + tsl_pkg::STYLE_POS];
            power_down_bit     <= pd_wr;
         end
         if (cfg_we && wr_word[8 + tsl_pkg::ONE_SHOT_POS]
             && conv_state == tsl_pkg::CONV_SHUT) begin
            one_shot_request <= 1'b1;
         end else if (conv_done) begin
            one_shot_request <= 1'b0;
         end
      end
   end

   // Run / power-down sequencer with per-resolution timer
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         conv_state   <= tsl_pkg::CONV_RUN;
         conv_timer   <= 32'h0;
         temp_reg     <= tsl_pkg::TEMP_RESET;
         converting_o <= 1'b1;
      end else begin
         case (conv_state)
            tsl_pkg::CONV_RUN: begin
               if (conv_done) begin
                  temp_reg   <= new_temp;
                  conv_timer <= 32'h0;
                  if (power_down_bit) begin
                     conv_state   <= tsl_pkg::CONV_SHUT;
                     converting_o <= 1'b0;
                  end
               end else begin
                  conv_timer <= conv_timer + 32'h1;
               end
            end
            tsl_pkg::CONV_SHUT: begin
               if (!power_down_bit || one_shot_request) begin
                  conv_state   <= tsl_pkg::CONV_RUN;
                  converting_o <= 1'b1;
                  conv_timer   <= 32'h0;
               end
            end
            default: begin
               conv_state <= tsl_pkg::CONV_RUN;
            end
         endcase
      end
   end

   // Limit registers, stored masked to resolution
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         low_alarm_limit  <= tsl_pkg::LOW_LIMIT_RESET;
         high_alarm_limit <= tsl_pkg::HIGH_LIMIT_RESET;
      end else if (lim_we) begin
         if (pointer == tsl_pkg::PTR_LOW_LIMIT) begin
            low_alarm_limit <= wr_word & res_mask(resolution_select);
         end else begin
            high_alarm_limit <= wr_word & res_mask(resolution_select);
         end
      end
   end

   // Fault queue: need count per queue_depth code
   wire [2:0] queue_need = (queue_depth == 2'h0) ? tsl_pkg::QUEUE_NEED_0 :
                           (queue_depth == 2'h1) ? tsl_pkg::QUEUE_NEED_1 :
                           (queue_depth == 2'h2) ? tsl_pkg::QUEUE_NEED_2 :
                                                   tsl_pkg::QUEUE_NEED_3;
   wire hi_hit = $signed(new_temp) >= $signed(high_alarm_limit);
   wire lo_hit = $signed(new_temp) < $signed(low_alarm_limit);

   logic       alarm_state;
   logic       int_flag;
   logic [2:0] fault_cnt;
   wire        fault_now = alarm_state ? lo_hit : hi_hit;
   wire        trip      = conv_done && fault_now && (fault_cnt + 3'h1 >= queue_need);

   // Comparator state plus sticky interrupt flag, cleared by a read
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         alarm_state <= 1'b0;
         int_flag    <= 1'b0;
         fault_cnt   <= 3'h0;
      end else begin
         if (lim_we) begin
            fault_cnt <= 3'h0;
         end else if (trip) begin
            fault_cnt <= 3'h0;
         end else if (conv_done) begin
            fault_cnt <= fault_now ? fault_cnt + 3'h1 : 3'h0;
         end
         if (trip) begin
            alarm_state <= ~alarm_state;
         end
         // Set wins over a read clear in the same cycle
         if (trip) begin
            int_flag <= 1'b1;
         end else if (rd_pulse) begin
            int_flag <= 1'b0;
         end
      end
   end

   // Pin level: style picks source, level picks polarity
   wire alarm_active = alarm_style_select ? int_flag : alarm_state;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         alarm_output_o <= 1'b1;
      end else begin
         alarm_output_o <= alert_active_level ? alarm_active : ~alarm_active;
      end
   end

endmodule // tsl_top
`default_nettype wire
